/* inc/ebtcu_pkg.sv */
// Shared constants, types and decode functions of the eight-bit timer counter
`default_nettype none
package ebtcu_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_COUNTER = 8'h00;
  localparam logic [7:0] OFF_COMPARE_A = 8'h04;
  localparam logic [7:0] OFF_COMPARE_B = 8'h08;
  localparam logic [7:0] OFF_CONTROL_A = 8'h0C;
  localparam logic [7:0] OFF_CONTROL_B = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;

  // Field positions
  localparam int CTLA_MODE_LSB = 0;
  localparam int CTLB_CS_LSB = 0;
  localparam int CTLB_MODE2_BIT = 3;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMPA_BIT = 1;
  localparam int FLAG_CMPB_BIT = 2;

  // Reset values and counter landmarks
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_STEP = 8'h01;

  // Clock select codes; 2..5 pick a prescaler strobe
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_PRESCALE_BASE = 3'h2;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRESCALE_TAPS = 4;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_PC_MAX = 3'h1,
    MODE_CTC = 3'h2,
    MODE_FAST_MAX = 3'h3,
    MODE_RSVD4 = 3'h4,
    MODE_PC_CMPA = 3'h5,
    MODE_RSVD6 = 3'h6,
    MODE_FAST_CMPA = 3'h7
  } ebtcu_mode_t;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} ebtcu_dir_t;

  typedef struct packed {
    logic compareB;
    logic compareA;
    logic overflow;
  } ebtcu_flags_t;

  typedef struct packed {
    logic [2:0] clockSelect;
    ebtcu_mode_t mode;
  } ebtcu_ctrl_t;

  // Up/down counting modes
  function automatic logic isDualSlope(input ebtcu_mode_t m);
    return (m == MODE_PC_MAX) || (m == MODE_PC_CMPA);
  endfunction

  // Single-slope pulse-width modes
  function automatic logic isFastPwm(input ebtcu_mode_t m);
    return (m == MODE_FAST_MAX) || (m == MODE_FAST_CMPA);
  endfunction

  // Modes whose top is compare register A
  function automatic logic topIsCompareA(input ebtcu_mode_t m);
    return (m == MODE_CTC) || (m == MODE_PC_CMPA) || (m == MODE_FAST_CMPA);
  endfunction

endpackage
`default_nettype wire

/* rtl/ebtcu_tick_select.sv */
// Timer tick source selection: stop, direct, prescaler strobes, count pin
`timescale 1ns/1ps
`default_nettype none
module ebtcu_tick_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] clockSelect,
  input wire logic [3:0] prescaleStrobes,
  input wire logic externalCountPin,
  output logic timerTick
);
  logic pinSync1_reg;
  logic pinSync2_reg;
  logic pinSync3_reg;
  logic pinLevel_reg;
  logic pinLevelOld_reg;
  logic pinRise;
  logic pinFall;
  logic [2:0] tapIndex;

  // Pin synchroniser; stages two and three must agree to move the level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
      pinSync3_reg <= 1'b0;
      pinLevel_reg <= 1'b0;
      pinLevelOld_reg <= 1'b0;
    end else begin
      pinSync1_reg <= externalCountPin;
      pinSync2_reg <= pinSync1_reg;
      pinSync3_reg <= pinSync2_reg;
      if (pinSync2_reg == pinSync3_reg) begin
        pinLevel_reg <= pinSync3_reg;
      end
      pinLevelOld_reg <= pinLevel_reg;
    end
  end

  // Edges of the filtered pin level
  assign pinRise = pinLevel_reg & ~pinLevelOld_reg;
  assign pinFall = ~pinLevel_reg & pinLevelOld_reg;
  assign tapIndex = clockSelect - ebtcu_pkg::CS_PRESCALE_BASE;

  // Source and edge choice; code zero gives no tick at all
  always_comb begin
    timerTick = 1'b0;
    unique case (clockSelect)
      ebtcu_pkg::CS_STOP: timerTick = 1'b0;
      ebtcu_pkg::CS_DIRECT: timerTick = 1'b1;
      ebtcu_pkg::CS_EXT_FALL: timerTick = pinFall;
      ebtcu_pkg::CS_EXT_RISE: timerTick = pinRise;
      default: timerTick = prescaleStrobes[tapIndex[1:0]];
    endcase
  end
endmodule // ebtcu_tick_select
`default_nettype wire

/* rtl/ebtcu_compare_unit.sv */
// One compare channel: optional double buffer and match detection
`timescale 1ns/1ps
`default_nettype none
module ebtcu_compare_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpuWrite,
  input wire logic [7:0] cpuData,
  input wire logic bufferMode,
  input wire logic reloadNow,
  input wire logic timerTick,
  input wire logic matchBlocked,
  input wire logic [7:0] counterValue,
  output logic [7:0] activeValue,
  output logic [7:0] cpuView,
  output logic matchEvent
);
  logic [7:0] bufferValue_reg;
  logic [7:0] activeValue_reg;

  // CPU side buffer, always written so it tracks in direct modes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bufferValue_reg <= ebtcu_pkg::REG_RESET;
    end else if (cpuWrite) begin
      bufferValue_reg <= cpuData;
    end
  end

  // Active value: direct write, or reload at the sequence landmark
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      activeValue_reg <= ebtcu_pkg::REG_RESET;
    end else if (cpuWrite && !bufferMode) begin
      activeValue_reg <= cpuData;
    end else if (bufferMode && reloadNow) begin
      activeValue_reg <= bufferValue_reg;
    end
  end

  assign activeValue = activeValue_reg;
  assign cpuView = bufferMode ? bufferValue_reg : activeValue_reg;
  // Match seen on a tick lands in the flag at that tick's edge
  assign matchEvent = timerTick && !matchBlocked &&
    (counterValue == activeValue_reg);

  a_direct_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    cpuWrite && !bufferMode |=> activeValue_reg == $past(cpuData))
    else $error("direct compare write not applied");
  a_buffered_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    bufferMode && !reloadNow |=> $stable(activeValue_reg))
    else $error("buffered compare changed outside reload");
endmodule // ebtcu_compare_unit
`default_nettype wire

/* rtl/ebtcu_timer.sv */
// Eight-bit timer counter with two compare units and an APB register file
// How it works
// - Counter and both compare registers are eight bits wide.
// - Three flags sit in a flag register, each gated by a mask bit.
// - Tick comes from the clock directly, prescaler strobes or the count pin, edge selectable.
// - Clock select zero gives no tick; the counter stays still.
// - Software reads and writes the counter whether or not ticks run.
// - A counter write beats any clear or count in the same cycle.
// - Each tick clears, increments or decrements by one per mode and direction.
// - Clear sets every counter bit to zero.
// - A bottom indication shows when the counter becomes zero.
// - 0xFF is the maximum; a top indication shows at sequence top.
// - Top is 0xFF or compare register A, depending on mode.
// - Mode field: two low bits in control A, high bit in control B.
// - Compare registers are compared on each tick; a match sets its flag.
// - Overflow flag is set as the selected mode dictates.
// - Compare registers double buffered only in pulse-width modes.
// - Normal mode counts up, wraps 0xFF to 0x00, sets overflow there.
// - A match sets its compare flag at the edge of the tick that sees it.
// - A counter write blocks all compare matches in the next tick.
`timescale 1ns/1ps
`default_nettype none
module ebtcu_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] prescaleStrobes,
  input wire logic externalCountPin,
  output logic timerIrq,
  output logic counterAtBottom,
  output logic counterAtTop
);
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic timerIrq_reg;
  logic counterAtBottom_reg;
  logic counterAtTop_reg;
  logic [7:0] counter_reg;
  logic [7:0] counter_next;
  ebtcu_pkg::ebtcu_dir_t dir_reg;
  ebtcu_pkg::ebtcu_dir_t dir_next;
  ebtcu_pkg::ebtcu_ctrl_t ctrl_reg;
  ebtcu_pkg::ebtcu_flags_t flags_reg;
  ebtcu_pkg::ebtcu_flags_t flags_next;
  ebtcu_pkg::ebtcu_flags_t mask_reg;
  logic block_reg;
  logic timerTick;
  logic apbAccess;
  logic apbCommit;
  logic addrHit;
  logic wrCounter;
  logic wrCompareA;
  logic wrCompareB;
  logic wrControlA;
  logic wrControlB;
  logic wrFlags;
  logic wrMask;
  logic [7:0] topValue;
  logic overflowHit;
  logic bufferMode;
  logic reloadNow;
  logic [7:0] compareA;
  logic [7:0] compareB;
  logic [7:0] viewA;
  logic [7:0] viewB;
  logic matchA;
  logic matchB;
  logic [31:0] readWord;

  // Write strobe for one register, taken only in the committing cycle
  function automatic logic regWrite(input logic commit,
                                    input logic [7:0] addr,
                                    input logic [7:0] offset);
    return commit && (addr == offset);
  endfunction

  // APB handshake: one wait state, then commit with pready high
  assign apbAccess = psel && penable;
  assign apbCommit = apbAccess && pready_reg && pwrite;
  assign wrCounter = regWrite(apbCommit, paddr, ebtcu_pkg::OFF_COUNTER);
  assign wrCompareA = regWrite(apbCommit, paddr, ebtcu_pkg::OFF_COMPARE_A);
  assign wrCompareB = regWrite(apbCommit, paddr, ebtcu_pkg::OFF_COMPARE_B);
  assign wrControlA = regWrite(apbCommit, paddr, ebtcu_pkg::OFF_CONTROL_A);
  assign wrControlB = regWrite(apbCommit, paddr, ebtcu_pkg::OFF_CONTROL_B);
  assign wrFlags = regWrite(apbCommit, paddr, ebtcu_pkg::OFF_FLAGS);
  assign wrMask = regWrite(apbCommit, paddr, ebtcu_pkg::OFF_MASK);

  // Read mux; compare reads show the buffer while it is in use
  always_comb begin
    readWord = 32'h0000_0000;
    addrHit = 1'b1;
    unique case (paddr)
      ebtcu_pkg::OFF_COUNTER: readWord[7:0] = counter_reg;
      ebtcu_pkg::OFF_COMPARE_A: readWord[7:0] = viewA;
      ebtcu_pkg::OFF_COMPARE_B: readWord[7:0] = viewB;
      ebtcu_pkg::OFF_CONTROL_A:
        readWord[ebtcu_pkg::CTLA_MODE_LSB +: 2] = ctrl_reg.mode[1:0];
      ebtcu_pkg::OFF_CONTROL_B: begin
        readWord[ebtcu_pkg::CTLB_CS_LSB +: 3] = ctrl_reg.clockSelect;
        readWord[ebtcu_pkg::CTLB_MODE2_BIT] = ctrl_reg.mode[2];
      end
      ebtcu_pkg::OFF_FLAGS: readWord[2:0] = flags_reg;
      ebtcu_pkg::OFF_MASK: readWord[2:0] = mask_reg;
      default: addrHit = 1'b0;
    endcase
  end

  // Bus answer registers; read data captured in the wait state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= apbAccess && !pready_reg;
      pslverr_reg <= apbAccess && !pready_reg && !addrHit;
      if (apbAccess && !pready_reg) begin
        prdata_reg <= readWord;
      end
    end
  end

  // Control fields; the mode field is split over two registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= '{clockSelect: ebtcu_pkg::CS_STOP,
                    mode: ebtcu_pkg::MODE_NORMAL};
    end else begin
      // Whole enum rebuilt; a part-select write to an enum is not legal
      if (wrControlA) begin
        ctrl_reg.mode <= ebtcu_pkg::ebtcu_mode_t'({ctrl_reg.mode[2],
          pwdata[ebtcu_pkg::CTLA_MODE_LSB +: 2]});
      end
      if (wrControlB) begin
        ctrl_reg.mode <= ebtcu_pkg::ebtcu_mode_t'({
          pwdata[ebtcu_pkg::CTLB_MODE2_BIT], ctrl_reg.mode[1:0]});
        ctrl_reg.clockSelect <= pwdata[ebtcu_pkg::CTLB_CS_LSB +: 3];
      end
    end
  end

  ebtcu_tick_select tickSelect (
    .clk(clk),
    .rst_n(rst_n),
    .clockSelect(ctrl_reg.clockSelect),
    .prescaleStrobes(prescaleStrobes),
    .externalCountPin(externalCountPin),
    .timerTick(timerTick)
  );

  // Sequence top: fixed maximum or compare A
  assign topValue = ebtcu_pkg::topIsCompareA(ctrl_reg.mode) ?
    compareA : ebtcu_pkg::CNT_MAX;

  // Next count and overflow condition for the current mode
  always_comb begin
    counter_next = counter_reg + ebtcu_pkg::CNT_STEP;
    dir_next = ebtcu_pkg::DIR_UP;
    overflowHit = (counter_reg == ebtcu_pkg::CNT_MAX);
    if (ebtcu_pkg::isDualSlope(ctrl_reg.mode)) begin
      dir_next = dir_reg;
      overflowHit = 1'b0;
      if (dir_reg == ebtcu_pkg::DIR_UP) begin
        if (counter_reg >= topValue) begin
          dir_next = ebtcu_pkg::DIR_DOWN;
          counter_next = (counter_reg == ebtcu_pkg::CNT_BOTTOM) ?
            ebtcu_pkg::CNT_BOTTOM : counter_reg - ebtcu_pkg::CNT_STEP;
        end
      end else if (counter_reg == ebtcu_pkg::CNT_BOTTOM) begin
        // Turning at bottom is the overflow point of up/down counting
        dir_next = ebtcu_pkg::DIR_UP;
        overflowHit = 1'b1;
      end else begin
        counter_next = counter_reg - ebtcu_pkg::CNT_STEP;
      end
    end else if ((ctrl_reg.mode == ebtcu_pkg::MODE_CTC ||
                  ctrl_reg.mode == ebtcu_pkg::MODE_FAST_CMPA) &&
                 counter_reg == topValue) begin
      counter_next = ebtcu_pkg::CNT_BOTTOM;
      if (ctrl_reg.mode == ebtcu_pkg::MODE_FAST_CMPA) begin
        overflowHit = 1'b1;
      end
    end
  end

  // Counter: a bus write always wins over the tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_reg <= ebtcu_pkg::REG_RESET;
      dir_reg <= ebtcu_pkg::DIR_UP;
    end else if (wrCounter) begin
      counter_reg <= pwdata[7:0];
    end else if (timerTick) begin
      counter_reg <= counter_next;
      dir_reg <= dir_next;
    end
  end

  // Match blocking lasts until the next tick, stopped or not
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      block_reg <= 1'b0;
    end else if (wrCounter) begin
      block_reg <= 1'b1;
    end else if (timerTick) begin
      block_reg <= 1'b0;
    end
  end

  // Buffer reload at bottom for fast modes, at top for up/down modes
  assign bufferMode = ebtcu_pkg::isDualSlope(ctrl_reg.mode) ||
    ebtcu_pkg::isFastPwm(ctrl_reg.mode);
  assign reloadNow = timerTick && !wrCounter &&
    ((ebtcu_pkg::isFastPwm(ctrl_reg.mode) &&
      counter_next == ebtcu_pkg::CNT_BOTTOM) ||
     (ebtcu_pkg::isDualSlope(ctrl_reg.mode) &&
      dir_reg == ebtcu_pkg::DIR_UP && counter_reg >= topValue));

  ebtcu_compare_unit compareUnitA (
    .clk(clk),
    .rst_n(rst_n),
    .cpuWrite(wrCompareA),
    .cpuData(pwdata[7:0]),
    .bufferMode(bufferMode),
    .reloadNow(reloadNow),
    .timerTick(timerTick),
    .matchBlocked(block_reg),
    .counterValue(counter_reg),
    .activeValue(compareA),
    .cpuView(viewA),
    .matchEvent(matchA)
  );

  ebtcu_compare_unit compareUnitB (
    .clk(clk),
    .rst_n(rst_n),
    .cpuWrite(wrCompareB),
    .cpuData(pwdata[7:0]),
    .bufferMode(bufferMode),
    .reloadNow(reloadNow),
    .timerTick(timerTick),
    .matchBlocked(block_reg),
    .counterValue(counter_reg),
    .activeValue(compareB),
    .cpuView(viewB),
    .matchEvent(matchB)
  );

  // Write-one-to-clear pattern from the bus word
  function automatic ebtcu_pkg::ebtcu_flags_t ebtcu_flags_clear(
      input logic [2:0] bits);
    return ebtcu_pkg::ebtcu_flags_t'(bits);
  endfunction

  // Sticky flags; a set in the clearing cycle survives the clear
  always_comb begin
    flags_next = flags_reg;
    if (wrFlags) begin
      flags_next = flags_reg & ~ebtcu_flags_clear(pwdata[2:0]);
    end
    flags_next.overflow = flags_next.overflow |
      (timerTick && !wrCounter && overflowHit);
    flags_next.compareA = flags_next.compareA | matchA;
    flags_next.compareB = flags_next.compareB | matchB;
  end

  // Flag and mask registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_reg <= ebtcu_pkg::FLAGS_RESET;
      mask_reg <= ebtcu_pkg::FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
      if (wrMask) begin
        mask_reg <= pwdata[2:0];
      end
    end
  end

  // Registered outputs; each trails its cause by one clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timerIrq_reg <= 1'b0;
      counterAtBottom_reg <= 1'b0;
      counterAtTop_reg <= 1'b0;
    end else begin
      timerIrq_reg <= |(flags_reg & mask_reg);
      counterAtBottom_reg <= (counter_reg == ebtcu_pkg::CNT_BOTTOM);
      counterAtTop_reg <= (counter_reg == topValue);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timerIrq = timerIrq_reg;
  assign counterAtBottom = counterAtBottom_reg;
  assign counterAtTop = counterAtTop_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Normal-mode wrap and the overflow it raises
  sequence sNormalWrap;
    ctrl_reg.mode == ebtcu_pkg::MODE_NORMAL && timerTick && !wrCounter &&
      counter_reg == ebtcu_pkg::CNT_MAX;
  endsequence
  sequence sOverflowSeen;
    counter_reg == ebtcu_pkg::CNT_BOTTOM && flags_reg.overflow;
  endsequence
  // Counter write followed by a matching tick
  sequence sBlockedTick;
    block_reg && timerTick && counter_reg == compareA && !flags_reg.compareA;
  endsequence

  a_normal_wrap: assert property (sNormalWrap |=> sOverflowSeen)
    else $error("normal wrap did not raise overflow");
  a_stopped_hold: assert property (
    ctrl_reg.clockSelect == ebtcu_pkg::CS_STOP && !wrCounter
      |=> $stable(counter_reg))
    else $error("counter moved while stopped");
  a_write_wins: assert property (
    wrCounter |=> counter_reg == $past(pwdata[7:0]))
    else $error("counter write lost to a tick");
  a_normal_step: assert property (
    ctrl_reg.mode == ebtcu_pkg::MODE_NORMAL && timerTick && !wrCounter
      |=> counter_reg == $past(counter_reg) + ebtcu_pkg::CNT_STEP)
    else $error("normal tick did not add one");
  a_ctc_clear: assert property (
    ctrl_reg.mode == ebtcu_pkg::MODE_CTC && timerTick && !wrCounter &&
      counter_reg == compareA |=> counter_reg == ebtcu_pkg::CNT_BOTTOM)
    else $error("match in clear mode did not zero counter");
  a_match_flag: assert property (
    timerTick && !block_reg && counter_reg == compareB
      |=> flags_reg.compareB)
    else $error("compare B match did not set flag");
  a_block_match: assert property (
    sBlockedTick |=> !flags_reg.compareA)
    else $error("match after counter write not blocked");
  // Sampled reset keeps the release edge out, where the mark is still 0
  a_bottom_mark: assert property (
    rst_n && counter_reg == ebtcu_pkg::CNT_BOTTOM |=> counterAtBottom)
    else $error("bottom indication missing");
  a_irq_level: assert property (
    ##1 timerIrq == |($past(flags_reg) & $past(mask_reg)))
    else $error("interrupt line disagrees with flags and mask");
  localparam int FLAG_CLR_PROBE = ebtcu_pkg::FLAG_OVF_BIT;
  a_flag_clear: assert property (
    wrFlags && pwdata[FLAG_CLR_PROBE] && !(timerTick && overflowHit)
      |=> !flags_reg.overflow)
    else $error("overflow flag not cleared by write of one");
  a_apb_answer: assert property (
    apbAccess && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("bus answer not one wait state");
endmodule // ebtcu_timer
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking testbench of the eight-bit timer counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] aCnt = ebtcu_pkg::OFF_COUNTER;
  localparam logic [7:0] aCmpA = ebtcu_pkg::OFF_COMPARE_A;
  localparam logic [7:0] aCmpB = ebtcu_pkg::OFF_COMPARE_B;
  localparam logic [7:0] aCtlA = ebtcu_pkg::OFF_CONTROL_A;
  localparam logic [7:0] aCtlB = ebtcu_pkg::OFF_CONTROL_B;
  localparam logic [7:0] aFlag = ebtcu_pkg::OFF_FLAGS;
  localparam logic [7:0] aMask = ebtcu_pkg::OFF_MASK;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] strobes = 4'h0;
  logic pin = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timerIrq;
  logic atBottom;
  logic atTop;
  logic [31:0] rdat;
  logic rerr;
  int errTotal = 0;
  int testsRun = 0;

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  ebtcu_timer uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prescaleStrobes(strobes),
    .externalCountPin(pin), .timerIrq(timerIrq),
    .counterAtBottom(atBottom), .counterAtTop(atTop)
  );

  // Verdict and end of run
  task automatic tally_and_finish;
    if (errTotal == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("FAIL %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp, "read data");
  endtask

  // Reset values, register width, unmapped address
  task automatic t_regs;
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
    wr(aCnt, 32'h1AB);
    rd(aCnt, 32'hAB);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    chk(rdat, 32'h0, "unmapped data");
    wr(aCnt, 32'h10);
    idle(10);
    rd(aCnt, 32'h10);
    wr(aCnt, 32'h0);
    idle(3);
    chk({31'h0, atBottom}, 32'h1, "bottom");
    wr(aCnt, 32'hFF);
    idle(3);
    chk({31'h0, atTop}, 32'h1, "top at max");
    chk({31'h0, atBottom}, 32'h0, "not bottom");
  endtask

  // Wrap through zero: overflow and both compare flags, irq gating
  task automatic t_overflow;
    wr(aMask, 32'h1);
    wr(aCnt, 32'hF0);
    wr(aCtlB, 32'h1);
    idle(40);
    wr(aCtlB, 32'h0);
    rd(aFlag, 32'h7);
    chk({31'h0, timerIrq}, 32'h1, "irq on");
    wr(aMask, 32'h0);
    idle(2);
    chk({31'h0, timerIrq}, 32'h0, "irq masked");
    wr(aFlag, 32'h7);
    rd(aFlag, 32'h0);
  endtask

  // Compare match, blocking by counter write, write priority
  task automatic t_compare;
    wr(aCmpA, 32'h20);
    wr(aCmpB, 32'h80);
    wr(aCnt, 32'h1E);
    wr(aCtlB, 32'h1);
    idle(20);
    wr(aCtlB, 32'h0);
    rd(aFlag, 32'h2);
    wr(aFlag, 32'h7);
    wr(aCtlB, 32'h1);
    wr(aCnt, 32'h20);
    idle(5);
    wr(aCnt, 32'h80);
    // Four ticks still land until the stop write commits
    wr(aCtlB, 32'h0);
    rd(aCnt, 32'h84);
    rd(aFlag, 32'h0);
  endtask

  // Top from compare A in clear-on-match, fast and up/down modes
  task automatic t_modes;
    wr(aCmpA, 32'h5);
    wr(aCtlA, 32'h2);
    wr(aCnt, 32'h0);
    wr(aCtlB, 32'h1);
    idle(30);
    wr(aCtlB, 32'h0);
    apb(1'b0, aCnt, 32'h0);
    chk({31'h0, rdat <= 32'h5}, 32'h1, "clear on match");
    wr(aCtlA, 32'h3);
    wr(aCtlB, 32'h9);
    idle(30);
    wr(aCtlB, 32'h8);
    apb(1'b0, aCnt, 32'h0);
    chk({31'h0, rdat <= 32'h5}, 32'h1, "fast top a");
    wr(aCtlA, 32'h1);
    wr(aCtlB, 32'h9);
    idle(30);
    wr(aCtlB, 32'h8);
    apb(1'b0, aCnt, 32'h0);
    chk({31'h0, rdat <= 32'h5}, 32'h1, "up down top a");
    wr(aCtlB, 32'h0);
    wr(aCtlA, 32'h0);
  endtask

  // Prescaler strobe and count pin edges as tick sources
  task automatic t_sources;
    wr(aCnt, 32'h0);
    wr(aCtlB, 32'h2);
    for (int i = 0; i < 4; i++) begin
      strobes <= (i == 3) ? 4'hE : 4'h1;
      idle(1);
      strobes <= 4'h0;
      idle(2);
    end
    rd(aCnt, 32'h3);
    wr(aCtlB, 32'h5);
    strobes <= 4'h8;
    idle(1);
    strobes <= 4'h0;
    rd(aCnt, 32'h4);
    wr(aCnt, 32'h0);
    wr(aCtlB, 32'h7);
    repeat (2) begin
      pin <= 1'b1;
      idle(10);
      pin <= 1'b0;
      idle(10);
    end
    rd(aCnt, 32'h2);
    wr(aCtlB, 32'h6);
    pin <= 1'b1;
    idle(10);
    pin <= 1'b0;
    idle(10);
    rd(aCnt, 32'h3);
  endtask

  // Main sequence
  initial begin
    idle(12);
    rst_n <= 1'b1;
    idle(1);
    t_regs();
    t_overflow();
    t_compare();
    t_modes();
    t_sources();
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial begin
    idle(20000);
    errTotal++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
